// >>> clock_source_regs.svh
// Register offsets, field positions and reset values of the clock source block.
// Assumes APB byte addressing with one 32-bit word per register.
`ifndef CLOCK_SOURCE_REGS_SVH
`define CLOCK_SOURCE_REGS_SVH

// ==========================================================================
// Register byte offsets
`define OFS_SRC_WORD 8'h00
`define OFS_OSC_WORD 8'h04
`define OFS_CTRL 8'h08
`define OFS_STATUS 8'h0C
`define OFS_POSTSCALE 8'h10
`define OFS_PIN 8'h14
`define OFS_REMAP 8'h18

// ==========================================================================
// Configuration word fields
`define SRC_SEL_LSB 0
`define TWO_SPEED_BIT 7
`define PRIM_MODE_LSB 0
`define PIN_FUNC_BIT 2
`define REMAP_ONCE_BIT 5
`define SWITCH_MODE_LSB 6

// ==========================================================================
// Control, status, pin and remap fields
`define CTRL_NEW_SRC_LSB 0
`define CTRL_LOCK_BIT 7
`define CTRL_REQ_BIT 8
`define STAT_CUR_SRC_LSB 0
`define STAT_SW_EN_BIT 4
`define STAT_FSM_EN_BIT 5
`define STAT_STARTUP_BIT 6
`define PIN_OUT_BIT 0
`define PIN_OE_BIT 1
`define PIN_IN_BIT 2
`define REMAP_MAP_LSB 0
`define REMAP_LOCK_BIT 16

// ==========================================================================
// Reset values
`define RST_CUR_SRC 3'h7
`define RST_POSTSCALE 3'h0
`define RST_WORD 16'hFFFF
`define RST_MAP 16'h0000

`endif

// >>> clock_source_pkg.sv
// Types shared by the clock source block.
// Assumes the constants of clock_source_regs.svh.
package clock_source_pkg;

    // ======================================================================
    // Clock source codes, same for selection and current source
    typedef enum logic [2:0] {
        SRC_FAST_RC = 3'b000,
        SRC_FAST_RC_WITH_PLL = 3'b001,
        SRC_PRIMARY = 3'b010,
        SRC_PRIMARY_PLL = 3'b011,
        SRC_SECONDARY = 3'b100,
        SRC_LOW_POWER_RC = 3'b101,
        SRC_FAST_RC_DIV_SIXTEEN = 3'b110,
        SRC_FAST_RC_DIV_N = 3'b111
    } src_e;

    // Primary oscillator modes
    typedef enum logic [1:0] {
        PRIM_EXTERNAL_CLOCK_INPUT = 2'b00,
        PRIM_MEDIUM_SPEED_CRYSTAL = 2'b01,
        PRIM_HIGH_SPEED_CRYSTAL = 2'b10,
        PRIM_OFF = 2'b11
    } prim_mode_e;

    // Latched configuration fields
    typedef struct packed {
        logic two_speed_startup;
        src_e initial_source_sel;
        logic [1:0] switch_monitor_mode;
        logic pin_remap_once;
        logic osc_pin_function;
        prim_mode_e primary_mode_sel;
    } cfg_s;

    // Selection state machine
    typedef enum logic [1:0] {
        ST_LOAD = 2'b00,
        ST_STARTUP = 2'b01,
        ST_RUN = 2'b10,
        ST_SWITCH = 2'b11
    } sel_state_e;

endpackage : clock_source_pkg

// >>> clock_source_config_select.sv
// Clock source selection from latched configuration words, with APB registers.
// Assumes config words are stable inputs and oscillator ready flags are asynchronous.
//
// Function
// - Instruction clock is system clock halved
// - Start on configured source, then switch only
// - Source code 000..111 selects eight sources
// - Erased word selects fast RC divide-by-N
// - Primary mode: off, high, medium, external
// - Primary mode matters only for primary sources
// - Pin function one drives instruction clock out
// - Crystal modes ignore the pin function bit only while a primary source is in use
// - Two-speed start runs fast RC until ready
// - Mode field gates switching and fail-safe monitor
// - Remap once option allows single pin reconfiguration
// - Config words are read-only, programmed externally
// - Postscaler divides fast RC by 1..256
// - Current source field reports source in use
//
// Local design decisions: the APB interface to the registers and the placing of the registers.
`include "clock_source_regs.svh"

module clock_source_config_select (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic PSEL,
    input wire logic PENABLE,
    input wire logic PWRITE,
    input wire logic [7:0] PADDR,
    input wire logic [31:0] PWDATA,
    output logic [31:0] PRDATA,
    output logic PREADY,
    output logic PSLVERR,
    input wire logic [15:0] CFG_SRC_WORD,
    input wire logic [15:0] CFG_OSC_WORD,
    input wire logic [7:0] SRC_READY,
    input wire logic PRIMARY_OUT_I,
    output logic PRIMARY_OUT_O,
    output logic PRIMARY_OUT_OE,
    output logic INSTR_CLK,
    output logic FAST_RC_DIV_TICK,
    output clock_source_pkg::src_e CUR_SRC,
    output clock_source_pkg::prim_mode_e PRIMARY_MODE,
    output logic FAIL_SAFE_EN,
    output logic [15:0] PIN_MAP,
    output logic PIN_MAP_LOCKED
);
    import clock_source_pkg::*;

    // ======================================================================
    // Synchronisers for oscillator ready flags and the pin input
    logic [8:0] sync1_q;
    logic [8:0] sync2_q;
    logic [7:0] ready;
    logic pin_in;

    // Two flops before any reader
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            sync1_q <= 9'h000;
            sync2_q <= 9'h000;
        end else begin
            sync1_q <= {PRIMARY_OUT_I, SRC_READY};
            sync2_q <= sync1_q;
        end
    end
    assign ready = sync2_q[7:0];
    assign pin_in = sync2_q[8];

    // ======================================================================
    // Configuration latch and source selection
    cfg_s cfg_q, cfg_d;
    logic [15:0] src_word_q, src_word_d;
    logic [15:0] osc_word_q, osc_word_d;
    sel_state_e state_q, state_d;
    src_e cur_q, cur_d;
    src_e target_q, target_d;
    logic switch_en;
    logic clk_lock_q, clk_lock_d;
    logic req_q, req_d;
    src_e new_src_q, new_src_d;
    logic wr_ctrl;

    // Mode field: 1x disables switching and monitor
    assign switch_en = ~cfg_q.switch_monitor_mode[1];

    // Next state of the selection machine
    always_comb begin
        cfg_d = cfg_q;
        src_word_d = src_word_q;
        osc_word_d = osc_word_q;
        state_d = state_q;
        cur_d = cur_q;
        target_d = target_q;
        case (state_q)
            ST_LOAD: begin
                // Capture once after reset, held from then on
                src_word_d = CFG_SRC_WORD;
                osc_word_d = CFG_OSC_WORD;
                cfg_d.two_speed_startup = CFG_SRC_WORD[`TWO_SPEED_BIT];
                cfg_d.initial_source_sel = src_e'(CFG_SRC_WORD[`SRC_SEL_LSB +: 3]);
                cfg_d.switch_monitor_mode = CFG_OSC_WORD[`SWITCH_MODE_LSB +: 2];
                cfg_d.pin_remap_once = CFG_OSC_WORD[`REMAP_ONCE_BIT];
                cfg_d.osc_pin_function = CFG_OSC_WORD[`PIN_FUNC_BIT];
                cfg_d.primary_mode_sel = prim_mode_e'(CFG_OSC_WORD[`PRIM_MODE_LSB +: 2]);
                target_d = src_e'(CFG_SRC_WORD[`SRC_SEL_LSB +: 3]);
                if (CFG_SRC_WORD[`TWO_SPEED_BIT]) begin
                    // Run on fast RC first
                    cur_d = SRC_FAST_RC;
                    state_d = ST_STARTUP;
                end else begin
                    // Direct start on the selected source
                    cur_d = src_e'(CFG_SRC_WORD[`SRC_SEL_LSB +: 3]);
                    state_d = ST_RUN;
                end
            end
            ST_STARTUP: begin
                // Hand over once the selected source is ready
                if (ready[target_q]) begin
                    cur_d = target_q;
                    state_d = ST_RUN;
                end
            end
            ST_RUN: begin
                // Later changes only by a permitted switch
                if (req_q && switch_en) begin
                    target_d = new_src_q;
                    state_d = ST_SWITCH;
                end
            end
            ST_SWITCH: begin
                if (ready[target_q]) begin
                    cur_d = target_q;
                    state_d = ST_RUN;
                end
            end
            default: begin
                state_d = ST_LOAD;
            end
        endcase
    end

    // Registers of the selection machine
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            cfg_q <= '1;
            src_word_q <= `RST_WORD;
            osc_word_q <= `RST_WORD;
            state_q <= ST_LOAD;
            cur_q <= src_e'(`RST_CUR_SRC); // Erased default
            target_q <= src_e'(`RST_CUR_SRC);
        end else begin
            cfg_q <= cfg_d;
            src_word_q <= src_word_d;
            osc_word_q <= osc_word_d;
            state_q <= state_d;
            cur_q <= cur_d;
            target_q <= target_d;
        end
    end

    // ======================================================================
    // Switch request, clock lock, postscaler, pin and remap registers
    logic [2:0] post_q, post_d;
    logic pin_out_q, pin_out_d;
    logic pin_oe_q, pin_oe_d;
    logic [15:0] map_q, map_d;
    logic map_lock_q, map_lock_d;
    logic map_locked_once_q, map_locked_once_d;
    logic wr_acc;
    logic lock_active;

    assign wr_acc = PSEL && PENABLE && PWRITE;
    assign wr_ctrl = wr_acc && (PADDR == `OFS_CTRL);
    // Lock counts only while switching is on and monitor off
    assign lock_active = clk_lock_q && (cfg_q.switch_monitor_mode == 2'b01);

    // Next values of software registers
    always_comb begin
        req_d = req_q;
        new_src_d = new_src_q;
        clk_lock_d = clk_lock_q;
        post_d = post_q;
        pin_out_d = pin_out_q;
        pin_oe_d = pin_oe_q;
        map_d = map_q;
        map_lock_d = map_lock_q;
        map_locked_once_d = map_locked_once_q;
        // Completion clears the request
        if (state_q == ST_SWITCH && ready[target_q]) begin
            req_d = 1'b0;
        end
        if (wr_ctrl) begin
            new_src_d = src_e'(PWDATA[`CTRL_NEW_SRC_LSB +: 3]);
            clk_lock_d = clk_lock_q | PWDATA[`CTRL_LOCK_BIT];
            // Requests ignored while switching is off or locked
            if (PWDATA[`CTRL_REQ_BIT] && switch_en && !lock_active && state_q == ST_RUN) begin
                req_d = 1'b1;
            end
        end
        if (wr_acc && PADDR == `OFS_POSTSCALE) begin
            post_d = PWDATA[2:0];
        end
        if (wr_acc && PADDR == `OFS_PIN) begin
            pin_out_d = PWDATA[`PIN_OUT_BIT];
            pin_oe_d = PWDATA[`PIN_OE_BIT];
        end
        if (wr_acc && PADDR == `OFS_REMAP) begin
            if (!map_lock_q) begin
                map_d = PWDATA[`REMAP_MAP_LSB +: 16];
            end
            // Once-mode lock cannot be released again
            if (PWDATA[`REMAP_LOCK_BIT]) begin
                map_lock_d = 1'b1;
                map_locked_once_d = 1'b1;
            end else if (!(cfg_q.pin_remap_once && map_locked_once_q)) begin
                map_lock_d = 1'b0;
            end
        end
    end

    // Software register flops
    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            req_q <= 1'b0;
            new_src_q <= SRC_FAST_RC;
            clk_lock_q <= 1'b0;
            post_q <= `RST_POSTSCALE;
            pin_out_q <= 1'b0;
            pin_oe_q <= 1'b0;
            map_q <= `RST_MAP;
            map_lock_q <= 1'b0;
            map_locked_once_q <= 1'b0;
        end else begin
            req_q <= req_d;
            new_src_q <= new_src_d;
            clk_lock_q <= clk_lock_d;
            post_q <= post_d;
            pin_out_q <= pin_out_d;
            pin_oe_q <= pin_oe_d;
            map_q <= map_d;
            map_lock_q <= map_lock_d;
            map_locked_once_q <= map_locked_once_d;
        end
    end

    // ======================================================================
    // Instruction clock and fast RC postscaler
    logic instr_q, instr_d;
    logic [7:0] div_cnt_q, div_cnt_d;
    logic [7:0] div_mask;
    logic tick_q, tick_d;

    // Ratio 1..64 by powers of two, code 111 is 256
    always_comb begin
        case (post_q)
            3'h7: div_mask = 8'hFF;
            default: div_mask = 8'((9'h001 << post_q) - 9'h001);
        endcase
    end

    // Halving toggle and postscaler count
    always_comb begin
        instr_d = (state_q == ST_LOAD) ? 1'b0 : ~instr_q;
        div_cnt_d = div_cnt_q + 8'h01;
        tick_d = (div_cnt_q & div_mask) == div_mask;
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            instr_q <= 1'b0;
            div_cnt_q <= 8'h00;
            tick_q <= 1'b0;
        end else begin
            instr_q <= instr_d;
            div_cnt_q <= div_cnt_d;
            tick_q <= tick_d;
        end
    end

    // ======================================================================
    // Second primary pin and top-level outputs
    logic crystal_mode;
    logic uses_primary;

    // Mode matters only for primary sources
    assign uses_primary = (cur_q == SRC_PRIMARY) || (cur_q == SRC_PRIMARY_PLL);
    assign crystal_mode = uses_primary && ((cfg_q.primary_mode_sel == PRIM_MEDIUM_SPEED_CRYSTAL)
                          || (cfg_q.primary_mode_sel == PRIM_HIGH_SPEED_CRYSTAL));

    // Pin owned by crystal, clock out or general I/O
    always_comb begin
        if (crystal_mode) begin
            PRIMARY_OUT_OE = 1'b0;
            PRIMARY_OUT_O = 1'b0;
        end else if (cfg_q.osc_pin_function) begin
            PRIMARY_OUT_OE = 1'b1;
            PRIMARY_OUT_O = instr_q;
        end else begin
            PRIMARY_OUT_OE = pin_oe_q;
            PRIMARY_OUT_O = pin_out_q;
        end
    end

    assign INSTR_CLK = instr_q;
    assign FAST_RC_DIV_TICK = tick_q;
    assign CUR_SRC = cur_q;
    assign PRIMARY_MODE = uses_primary ? cfg_q.primary_mode_sel : PRIM_OFF;
    assign FAIL_SAFE_EN = (cfg_q.switch_monitor_mode == 2'b00);
    assign PIN_MAP = map_q;
    assign PIN_MAP_LOCKED = map_lock_q;

    // ======================================================================
    // APB slave: read data prepared in setup, zero wait states
    logic [31:0] rdata_q, rdata_d;
    logic err_q, err_d;

    always_comb begin
        rdata_d = rdata_q;
        err_d = err_q;
        if (PSEL && !PENABLE) begin
            rdata_d = 32'h0000_0000;
            err_d = 1'b0;
            case (PADDR)
                `OFS_SRC_WORD: rdata_d[15:0] = src_word_q;
                `OFS_OSC_WORD: rdata_d[15:0] = osc_word_q;
                `OFS_CTRL: begin
                    rdata_d[`CTRL_NEW_SRC_LSB +: 3] = new_src_q;
                    rdata_d[`CTRL_LOCK_BIT] = clk_lock_q;
                    rdata_d[`CTRL_REQ_BIT] = req_q;
                end
                `OFS_STATUS: begin
                    rdata_d[`STAT_CUR_SRC_LSB +: 3] = cur_q;
                    rdata_d[`STAT_SW_EN_BIT] = switch_en;
                    rdata_d[`STAT_FSM_EN_BIT] = FAIL_SAFE_EN;
                    rdata_d[`STAT_STARTUP_BIT] = (state_q == ST_STARTUP);
                end
                `OFS_POSTSCALE: rdata_d[2:0] = post_q;
                `OFS_PIN: begin
                    rdata_d[`PIN_OUT_BIT] = pin_out_q;
                    rdata_d[`PIN_OE_BIT] = pin_oe_q;
                    rdata_d[`PIN_IN_BIT] = pin_in;
                end
                `OFS_REMAP: begin
                    rdata_d[`REMAP_MAP_LSB +: 16] = map_q;
                    rdata_d[`REMAP_LOCK_BIT] = map_lock_q;
                end
                default: err_d = 1'b1;
            endcase
        end
    end

    always_ff @(posedge CLK) begin
        if (SYS_RST) begin
            rdata_q <= 32'h0000_0000;
            err_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            err_q <= err_d;
        end
    end

    assign PRDATA = rdata_q;
    assign PREADY = 1'b1;
    assign PSLVERR = PSEL && PENABLE && err_q;

    // ======================================================================
    // Assertions
    default clocking cb @(posedge CLK); endclocking
    default disable iff (SYS_RST);

    sequence load_seq;
        state_q == ST_LOAD;
    endsequence

    sequence direct_start_seq;
        load_seq ##0 !CFG_SRC_WORD[`TWO_SPEED_BIT];
    endsequence

    instr_half_a: assert property (state_q != ST_LOAD |=> INSTR_CLK != $past(INSTR_CLK))
        else $error("instruction clock did not toggle");

    start_source_a: assert property (direct_start_seq |=> CUR_SRC == $past(CFG_SRC_WORD[2:0]))
        else $error("power-on source differs from selection");

    erased_default_a: assert property (load_seq ##0 CFG_SRC_WORD == 16'hFFFF
        |=> target_q == SRC_FAST_RC_DIV_N && state_q == ST_STARTUP)
        else $error("erased word did not pick divide-by-N");

    two_speed_a: assert property (load_seq ##0 CFG_SRC_WORD[`TWO_SPEED_BIT]
        |=> CUR_SRC == SRC_FAST_RC && state_q == ST_STARTUP)
        else $error("two-speed start not on fast RC");

    crystal_pin_a: assert property (crystal_mode |-> !PRIMARY_OUT_OE)
        else $error("pin driven in crystal mode");

    pin_clock_a: assert property (!crystal_mode && cfg_q.osc_pin_function
        |-> PRIMARY_OUT_OE && PRIMARY_OUT_O == INSTR_CLK)
        else $error("instruction clock not on pin");

    no_switch_a: assert property (!switch_en && state_q == ST_RUN
        |=> $stable(CUR_SRC) && !req_q)
        else $error("source changed while switching disabled");

    config_hold_a: assert property (state_q != ST_LOAD |=> $stable(cfg_q))
        else $error("configuration changed after load");

    monitor_mode_a: assert property (cfg_q.switch_monitor_mode[1]
        |-> !FAIL_SAFE_EN && !switch_en)
        else $error("mode 1x left switching or monitor on");

    remap_once_a: assert property (cfg_q.pin_remap_once && map_locked_once_q && map_lock_q
        |=> map_lock_q && $stable(PIN_MAP))
        else $error("remap changed after one-time lock");

endmodule : clock_source_config_select

// >>> config_programmer_model.sv
// Device programmer model: presents the two nonvolatile configuration words.
// Assumes the bench sets the fields before it releases reset.
module config_programmer_model
(
    input clock_source_pkg::cfg_s FIELDS,
    output logic [15:0] SRC_WORD,
    output logic [15:0] OSC_WORD
);
    import clock_source_pkg::*;

    // ======================================================================
    // Word images, unused positions programmed as one
    always_comb begin
        SRC_WORD = {8'hFF, FIELDS.two_speed_startup, 4'hF, FIELDS.initial_source_sel};
        OSC_WORD = {8'hFF, FIELDS.switch_monitor_mode, FIELDS.pin_remap_once, 2'h3,
                    FIELDS.osc_pin_function, FIELDS.primary_mode_sel};
    end
endmodule : config_programmer_model

// >>> test_clock_source_config_select.sv
// Self-checking bench of the clock source selection block.
// Assumes the programmer model and the register header of the design.
`include "clock_source_regs.svh"

module test_clock_source_config_select;
    timeunit 1ns;
    timeprecision 100ps;
    import clock_source_pkg::*;

    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic [15:0] src_word;
    logic [15:0] osc_word;
    logic [7:0] src_ready = 8'hFF;
    logic primary_out_i = 1'b0;
    logic primary_out_o;
    logic primary_out_oe;
    logic instr_clk;
    logic fast_rc_div_tick;
    src_e cur_src;
    prim_mode_e primary_mode;
    logic fail_safe_en;
    logic [15:0] pin_map;
    logic pin_map_locked;
    cfg_s fields = 10'h3FF;
    int fail_count = 0;
    int samples_checked = 0;
    logic [31:0] rd;
    logic err;

    // ======================================================================
    // Clock and instances
    always #2.5 clk = ~clk;

    config_programmer_model programmer (.FIELDS(fields), .SRC_WORD(src_word),
        .OSC_WORD(osc_word));

    clock_source_config_select DUT (.CLK(clk), .SYS_RST(sys_rst), .PSEL(psel),
        .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
        .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CFG_SRC_WORD(src_word),
        .CFG_OSC_WORD(osc_word), .SRC_READY(src_ready), .PRIMARY_OUT_I(primary_out_i),
        .PRIMARY_OUT_O(primary_out_o), .PRIMARY_OUT_OE(primary_out_oe),
        .INSTR_CLK(instr_clk), .FAST_RC_DIV_TICK(fast_rc_div_tick), .CUR_SRC(cur_src),
        .PRIMARY_MODE(primary_mode), .FAIL_SAFE_EN(fail_safe_en), .PIN_MAP(pin_map),
        .PIN_MAP_LOCKED(pin_map_locked));

    // ======================================================================
    // Shared tasks
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s", $time, msg);
        end
    endtask : chk

    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : end_of_test

    // One APB transfer, held until pready is seen high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        logic rdy;
        n = 0;
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
            rdy = pready;
            n++;
        end while (rdy !== 1'b1 && n < 16);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
        if (rdy !== 1'b1) begin
            fail_count++;
            end_of_test();
        end
    endtask : apb

    task automatic restart(input cfg_s c);
        fields <= c;
        sys_rst <= 1'b1;
        repeat (5) @(posedge clk);
        sys_rst <= 1'b0;
        repeat (4) @(posedge clk);
    endtask : restart

    task automatic wait_src(input src_e s, input int lim);
        int n;
        n = 0;
        while (cur_src !== s && n < lim) begin
            @(posedge clk);
            n++;
        end
        if (cur_src !== s) begin
            fail_count++;
            end_of_test();
        end
    endtask : wait_src

    // Cycles from one postscaler tick to the next
    task automatic tick_gap(output int n);
        // Skip the tick launched under the old ratio
        @(posedge clk);
        n = 0;
        while (fast_rc_div_tick !== 1'b1 && n < 300) begin
            @(posedge clk);
            n++;
        end
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (fast_rc_div_tick !== 1'b1 && n < 300);
    endtask : tick_gap

    function automatic cfg_s mk(logic ts, logic [2:0] s, logic [1:0] sw, logic ro,
                                logic pf, logic [1:0] pm);
        return {ts, s, sw, ro, pf, pm};
    endfunction : mk

    // Rows: source, switch mode, pin function, primary mode | source, mode, monitor, drive
    logic [14:0] rows [8] = '{15'b000_11_1_11_000_11_0_1, 15'b001_01_0_00_001_11_0_0,
        15'b010_00_1_00_010_00_1_1, 15'b010_00_1_01_010_01_1_0, 15'b011_01_1_10_011_10_0_0,
        15'b100_10_1_10_100_11_0_1, 15'b101_11_0_01_101_11_0_0, 15'b110_00_1_00_110_11_1_1};

    // ======================================================================
    // Main sequence
    initial begin
        logic [2:0] s;
        logic [2:0] ecur;
        logic [1:0] sw;
        logic [1:0] pm;
        logic [1:0] epm;
        logic pf;
        logic efs;
        logic eoe;
        logic a;
        int n;
        foreach (rows[i]) begin
            {s, sw, pf, pm, ecur, epm, efs, eoe} = rows[i];
            restart(mk(1'b0, s, sw, 1'b0, pf, pm));
            chk(cur_src, ecur, "power-on source");
            chk(primary_mode, epm, "primary mode");
            chk(fail_safe_en, efs, "monitor enable");
            chk(primary_out_oe, eoe, "pin drive");
            if (eoe) chk(primary_out_o, instr_clk, "pin value");
            apb(1'b0, `OFS_STATUS, 32'h0);
            chk(rd[4], !sw[1], "switch enable");
            $display("row %0d done", i);
        end
        // Erased words, register access and postscaler
        restart(10'h3FF);
        chk(cur_src, 3'h7, "erased source");
        for (int i = 0; i < 4; i++) begin
            a = instr_clk;
            @(posedge clk);
            chk(instr_clk, !a, "instruction clock");
        end
        apb(1'b1, `OFS_SRC_WORD, 32'h0);
        apb(1'b0, `OFS_SRC_WORD, 32'h0);
        chk(rd, 32'h0000_FFFF, "source word");
        apb(1'b0, 8'h40, 32'h0);
        chk(err, 1'b1, "unmapped error");
        chk(rd, 32'h0, "unmapped data");
        apb(1'b0, `OFS_POSTSCALE, 32'h0);
        chk(rd, 32'h0, "postscaler reset");
        for (int c = 0; c < 8; c++) begin
            apb(1'b1, `OFS_POSTSCALE, c);
            tick_gap(n);
            chk(n, (c == 7) ? 256 : (1 << c), "tick ratio");
        end
        apb(1'b1, `OFS_CTRL, 32'h0000_0101);
        repeat (20) @(posedge clk);
        chk(cur_src, 3'h7, "switch refused");
        fields <= mk(1'b0, 3'h0, 2'h1, 1'b0, 1'b0, 2'h0);
        repeat (4) @(posedge clk);
        apb(1'b0, `OFS_SRC_WORD, 32'h0);
        chk(cur_src, 3'h7, "source held");
        chk(rd, 32'h0000_FFFF, "words held");
        $display("erased test done");
        // Clock switch waits for ready, then lock
        restart(mk(1'b0, 3'h0, 2'h1, 1'b0, 1'b1, 2'h0));
        src_ready <= 8'hFB;
        apb(1'b1, `OFS_CTRL, 32'h0000_0102);
        repeat (10) @(posedge clk);
        chk(cur_src, 3'h0, "switch waits");
        src_ready <= 8'hFF;
        wait_src(SRC_PRIMARY, 20);
        apb(1'b0, `OFS_CTRL, 32'h0);
        chk(rd[8], 1'b0, "request cleared");
        chk(primary_mode, 2'h0, "mode after switch");
        apb(1'b1, `OFS_CTRL, 32'h0000_0080);
        apb(1'b1, `OFS_CTRL, 32'h0000_0104);
        repeat (20) @(posedge clk);
        chk(cur_src, 3'h2, "locked source");
        $display("switch test done");
        // Two-speed start
        src_ready <= 8'h00;
        restart(mk(1'b1, 3'h4, 2'h3, 1'b0, 1'b0, 2'h3));
        chk(cur_src, 3'h0, "fast start");
        src_ready <= 8'h10;
        wait_src(SRC_SECONDARY, 10);
        $display("two-speed test done");
        // Remap lock, once and repeated
        for (int ro = 1; ro >= 0; ro--) begin
            restart(mk(1'b0, 3'h0, 2'h3, ro[0], 1'b0, 2'h3));
            apb(1'b1, `OFS_REMAP, 32'h0001_1234);
            chk({pin_map_locked, pin_map}, 17'h1_1234, "map and lock");
            apb(1'b1, `OFS_REMAP, 32'h0000_5678);
            chk(pin_map_locked, ro[0], "unlock");
            apb(1'b1, `OFS_REMAP, 32'h0000_5678);
            chk(pin_map, ro[0] ? 16'h1234 : 16'h5678, "second map");
        end
        $display("remap test done");
        // Pin as general I/O when pin function is zero
        primary_out_i <= 1'b1;
        apb(1'b1, `OFS_PIN, 32'h0000_0003);
        chk({primary_out_oe, primary_out_o}, 2'b11, "pin as I/O");
        apb(1'b0, `OFS_PIN, 32'h0);
        chk(rd, 32'h0000_0007, "pin readback");
        $display("pin test done");
        end_of_test();
    end

    // Overall limit on run time
    initial begin
        #400us;
        fail_count++;
        end_of_test();
    end
endmodule : test_clock_source_config_select
